// file: hw/bpm_compare.sv
/*
 * one access comparator: range test and masked value test, combined per mode.
 * assumes all inputs are stable within the cycle; purely combinational.
 */
`timescale 1ns/1ps
module bpm_compare #(
    parameter int ADDR_W = 32,
    parameter int DATA_W = 32
) (
    input  wire logic [ADDR_W-1:0] addr_i,      // access address
    input  wire logic [DATA_W-1:0] data_i,      // access data
    input  wire logic [ADDR_W-1:0] low_i,       // range low bound
    input  wire logic [ADDR_W-1:0] high_i,      // range high bound
    input  wire logic              range_inv_i, // match outside range
    input  wire logic [DATA_W-1:0] value_i,     // compare value
    input  wire logic [DATA_W-1:0] mask_i,      // compare mask
    input  wire logic              value_inv_i, // match on differ
    input  wire logic [1:0]        mode_i,      // which tests apply
    output logic                   match_o      // combined result
);
    import bpm_pkg::*;

    // ************************************************************
    // tests
    // ************************************************************
    logic in_range;  // low <= addr <= high
    logic addr_hit;  // range result after invert
    logic val_eq;    // masked equality
    logic val_hit;   // value result after invert

    // plain unsigned compare, no aperture decode
    assign in_range = (addr_i >= low_i) && (addr_i <= high_i);
    assign addr_hit = range_inv_i ? !in_range : in_range;
    assign val_eq   = ((data_i & mask_i) == (value_i & mask_i));
    assign val_hit  = value_inv_i ? !val_eq : val_eq;

    // combine per mode
    always_comb begin
        case (mode_i)
            BPM_MODE_ADDR:  match_o = addr_hit;            // address only
            BPM_MODE_VALUE: match_o = val_hit;             // value only
            BPM_MODE_BOTH:  match_o = addr_hit && val_hit; // both together
            default:        match_o = 1'b0;                // disabled
        endcase
    end

endmodule

// file: hw/bpm_pkg.sv
/*
 * package of the breakpoint match unit: register offsets, control field
 * positions, reset values and mode codes.
 * assumes a 32-bit memory-mapped register port with offsets taken
 * relative to the register window base, and a core with two load/store ports.
 */
// Functional notes
// - instruction matching only while instr_bp_enable set
// - non-inverted: low <= iaddr <= high matches
// - inverted: iaddr below low or above high
// - each instruction match gives one event pulse
// - reset clears instruction control register
// - instruction range registers not reset
// - data_bp_mode zero disables data events
// - modes 1,3 compare selected load/store addresses
// - data range inside or outside per invert
// - range compare ignores memory aperture
// - modes 2,3 compare selected load/store data
// - only mask-one bits take part
// - value_compare_invert chooses equal or differ
// - mode 3 needs address and value together
// - each data match gives a count event
// - both load/store ports judged independently
// - reset clears data control register only
// - data range, value, mask not reset
// - count per cycle is zero, one or two
package bpm_pkg;

    // ************************************************************
    // register offsets from the window base
    // ************************************************************
    localparam logic [31:0] BPM_OFF_INSTR_CTL   = 32'h0010_1000; // instr_bp_control
    localparam logic [31:0] BPM_OFF_INSTR_LOW   = 32'h0010_1010; // instruction range low
    localparam logic [31:0] BPM_OFF_INSTR_HIGH  = 32'h0010_1014; // instruction range high
    localparam logic [31:0] BPM_OFF_DATA_CTL    = 32'h0010_1020; // data_bp_control
    localparam logic [31:0] BPM_OFF_DATA_LOW    = 32'h0010_1030; // data_bp_range_low
    localparam logic [31:0] BPM_OFF_DATA_HIGH   = 32'h0010_1034; // data_bp_range_high
    localparam logic [31:0] BPM_OFF_DATA_VALUE  = 32'h0010_1038; // data_bp_compare_value
    localparam logic [31:0] BPM_OFF_DATA_MASK   = 32'h0010_103C; // data_bp_compare_mask

    // ************************************************************
    // control field positions
    // ************************************************************
    localparam int BPM_ICTL_ENABLE_BIT  = 0; // instr_bp_enable
    localparam int BPM_ICTL_INVERT_BIT  = 1; // instr_range_invert
    localparam int BPM_ICTL_WIDTH       = 2;
    localparam int BPM_DCTL_MODE_LSB    = 0; // data_bp_mode, two bits
    localparam int BPM_DCTL_LOADS_BIT   = 2; // match_loads
    localparam int BPM_DCTL_STORES_BIT  = 3; // match_stores
    localparam int BPM_DCTL_RINV_BIT    = 4; // data_range_invert
    localparam int BPM_DCTL_VINV_BIT    = 5; // value_compare_invert
    localparam int BPM_DCTL_WIDTH       = 6;

    // ************************************************************
    // reset values and mode codes
    // ************************************************************
    localparam logic [BPM_ICTL_WIDTH-1:0] BPM_ICTL_RESET = 2'h0;
    localparam logic [BPM_DCTL_WIDTH-1:0] BPM_DCTL_RESET = 6'h00;
    localparam logic [1:0] BPM_MODE_OFF   = 2'h0; // no data events
    localparam logic [1:0] BPM_MODE_ADDR  = 2'h1; // address range only
    localparam logic [1:0] BPM_MODE_VALUE = 2'h2; // masked value only
    localparam logic [1:0] BPM_MODE_BOTH  = 2'h3; // address and value together

endpackage

// file: hw/bpm_unit.sv
/*
 * breakpoint match unit: memory-mapped control registers, instruction
 * address range matching and dual-port data address/value matching, with
 * registered event pulses offered to the timers as count sources.
 * assumes a single cpu clock, synchronous inputs, and a simple register
 * port whose write and read strobes each last one cycle.
 */
`timescale 1ns/1ps
module bpm_unit #(
    parameter int ADDR_W  = 32,
    parameter int DATA_W  = 32,
    parameter int N_PORTS = 2
) (
    input  wire logic                         clk_i,          // cpu clock
    input  wire logic                         arst_n_i,       // async reset, low
    input  wire logic                         ce_i,           // clock enable
    // register port
    input  wire logic [31:0]                  reg_addr_i,     // offset from window base
    input  wire logic                         reg_wr_i,       // write strobe
    input  wire logic                         reg_rd_i,       // read strobe
    input  wire logic [31:0]                  reg_wdata_i,    // write data
    output logic [31:0]                       reg_rdata_o,    // read data, next cycle
    // instruction fetch
    input  wire logic                         instr_valid_i,  // address issued
    input  wire logic [ADDR_W-1:0]            instr_addr_i,   // instruction address
    // load/store ports
    input  wire logic [N_PORTS-1:0]           ls_valid_i,     // access issued
    input  wire logic [N_PORTS-1:0]           ls_store_i,     // 1 store, 0 load
    input  wire logic [N_PORTS-1:0][ADDR_W-1:0] ls_addr_i,    // access address
    input  wire logic [N_PORTS-1:0][DATA_W-1:0] ls_data_i,    // access data
    // timer count sources
    output logic                              instr_bp_event_o, // instruction match
    output logic [N_PORTS-1:0]                data_bp_event_o,  // data match per port
    output logic [1:0]                        data_bp_count_o   // data matches this cycle
);
    import bpm_pkg::*;

    // ************************************************************
    // registers
    // ************************************************************
    logic [BPM_ICTL_WIDTH-1:0] ictl_q;      // instr_bp_control
    logic [BPM_DCTL_WIDTH-1:0] dctl_q;      // data_bp_control
    logic [ADDR_W-1:0]         ilow_q;      // instruction range low
    logic [ADDR_W-1:0]         ihigh_q;     // instruction range high
    logic [ADDR_W-1:0]         dlow_q;      // data range low
    logic [ADDR_W-1:0]         dhigh_q;     // data range high
    logic [DATA_W-1:0]         dval_q;      // compare value
    logic [DATA_W-1:0]         dmask_q;     // compare mask
    logic [31:0]               rdata_q;     // read data
    logic                      ievent_q;    // instruction event
    logic [N_PORTS-1:0]        devent_q;    // data events
    logic [1:0]                dcount_q;    // data event count

    // decoded fields
    logic       ictl_en;     // instr_bp_enable
    logic       ictl_inv;    // instr_range_invert
    logic [1:0] dctl_mode;   // data_bp_mode
    logic       dctl_loads;  // match_loads
    logic       dctl_stores; // match_stores
    logic       dctl_rinv;   // data_range_invert
    logic       dctl_vinv;   // value_compare_invert

    assign ictl_en     = ictl_q[BPM_ICTL_ENABLE_BIT];
    assign ictl_inv    = ictl_q[BPM_ICTL_INVERT_BIT];
    assign dctl_mode   = dctl_q[BPM_DCTL_MODE_LSB +: 2];
    assign dctl_loads  = dctl_q[BPM_DCTL_LOADS_BIT];
    assign dctl_stores = dctl_q[BPM_DCTL_STORES_BIT];
    assign dctl_rinv   = dctl_q[BPM_DCTL_RINV_BIT];
    assign dctl_vinv   = dctl_q[BPM_DCTL_VINV_BIT];

    // ************************************************************
    // register writes
    // ************************************************************
    // control registers, cleared by reset
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ictl_q <= BPM_ICTL_RESET;
            dctl_q <= BPM_DCTL_RESET;
        end else if (ce_i && reg_wr_i) begin
            if (reg_addr_i == BPM_OFF_INSTR_CTL) begin
                ictl_q <= reg_wdata_i[BPM_ICTL_WIDTH-1:0];
            end
            if (reg_addr_i == BPM_OFF_DATA_CTL) begin
                dctl_q <= reg_wdata_i[BPM_DCTL_WIDTH-1:0];
            end
        end
    end

    // range, value and mask registers, left unreset
    // no reset on bounds and compare words
    always_ff @(posedge clk_i) begin
        if (ce_i && reg_wr_i) begin
            case (reg_addr_i)
                BPM_OFF_INSTR_LOW:  ilow_q  <= reg_wdata_i[ADDR_W-1:0];
                BPM_OFF_INSTR_HIGH: ihigh_q <= reg_wdata_i[ADDR_W-1:0];
                BPM_OFF_DATA_LOW:   dlow_q  <= reg_wdata_i[ADDR_W-1:0];
                BPM_OFF_DATA_HIGH:  dhigh_q <= reg_wdata_i[ADDR_W-1:0];
                BPM_OFF_DATA_VALUE: dval_q  <= reg_wdata_i[DATA_W-1:0];
                BPM_OFF_DATA_MASK:  dmask_q <= reg_wdata_i[DATA_W-1:0];
                default:            ;  // unmapped writes ignored
            endcase
        end
    end

    // ************************************************************
    // register reads
    // ************************************************************
    // read data registered; unmapped offsets read zero
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (ce_i && reg_rd_i) begin
            case (reg_addr_i)
                BPM_OFF_INSTR_CTL:  rdata_q <= 32'(ictl_q);
                BPM_OFF_INSTR_LOW:  rdata_q <= 32'(ilow_q);
                BPM_OFF_INSTR_HIGH: rdata_q <= 32'(ihigh_q);
                BPM_OFF_DATA_CTL:   rdata_q <= 32'(dctl_q);
                BPM_OFF_DATA_LOW:   rdata_q <= 32'(dlow_q);
                BPM_OFF_DATA_HIGH:  rdata_q <= 32'(dhigh_q);
                BPM_OFF_DATA_VALUE: rdata_q <= 32'(dval_q);
                BPM_OFF_DATA_MASK:  rdata_q <= 32'(dmask_q);
                default:            rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // ************************************************************
    // comparators
    // ************************************************************
    logic               imatch;   // instruction range match
    logic [N_PORTS-1:0] dmatch;   // data match per port
    logic [N_PORTS-1:0] dsel;     // access kind selected

    // instruction path uses the range test only
    bpm_compare #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_icmp (
        .addr_i      (instr_addr_i),
        .data_i      ({DATA_W{1'b0}}),
        .low_i       (ilow_q),
        .high_i      (ihigh_q),
        .range_inv_i (ictl_inv),
        .value_i     ({DATA_W{1'b0}}),
        .mask_i      ({DATA_W{1'b0}}),
        .value_inv_i (1'b0),
        .mode_i      (BPM_MODE_ADDR),
        .match_o     (imatch)
    );

    // one independent comparator per load/store port
    for (genvar p = 0; p < N_PORTS; p++) begin : g_port
        assign dsel[p] = ls_valid_i[p] && (ls_store_i[p] ? dctl_stores : dctl_loads);
        bpm_compare #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_dcmp (
            .addr_i      (ls_addr_i[p]),
            .data_i      (ls_data_i[p]),
            .low_i       (dlow_q),
            .high_i      (dhigh_q),
            .range_inv_i (dctl_rinv),
            .value_i     (dval_q),
            .mask_i      (dmask_q),
            .value_inv_i (dctl_vinv),
            .mode_i      (dctl_mode),
            .match_o     (dmatch[p])
        );
    end

    // ************************************************************
    // event outputs
    // ************************************************************
    // instruction event pulse
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ievent_q <= 1'b0;
        end else if (ce_i) begin
            // gated by enable, one pulse per match
            ievent_q <= ictl_en && instr_valid_i && imatch;
        end
    end

    // data event pulses and per-cycle count
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            devent_q <= '0;
            dcount_q <= 2'h0;
        end else if (ce_i) begin
            devent_q <= (dctl_mode != BPM_MODE_OFF) ? (dsel & dmatch) : '0;
            // zero, one or two per cycle
            dcount_q <= (dctl_mode != BPM_MODE_OFF) ? 2'($countones(dsel & dmatch)) : 2'h0;
        end
    end

    assign reg_rdata_o      = rdata_q;
    assign instr_bp_event_o = ievent_q;
    assign data_bp_event_o  = devent_q;
    assign data_bp_count_o  = dcount_q;

    // ************************************************************
    // assertions
    // ************************************************************
    property p_instr_hit;
        @(posedge clk_i) disable iff (!arst_n_i)
        (ce_i && ictl_en && !ictl_inv && instr_valid_i &&
         instr_addr_i >= ilow_q && instr_addr_i <= ihigh_q) |=> instr_bp_event_o;
    endproperty
    a_instr_hit: assert property (p_instr_hit) else $error("instr match missed");

    property p_instr_off;
        @(posedge clk_i) disable iff (!arst_n_i)
        (ce_i && !ictl_en) |=> !instr_bp_event_o;
    endproperty
    a_instr_off: assert property (p_instr_off) else $error("instr event while off");

    property p_instr_inv;
        @(posedge clk_i) disable iff (!arst_n_i)
        (ce_i && ictl_en && ictl_inv && instr_valid_i &&
         (instr_addr_i < ilow_q || instr_addr_i > ihigh_q)) |=> instr_bp_event_o;
    endproperty
    a_instr_inv: assert property (p_instr_inv) else $error("inverted match missed");

    property p_data_off;
        @(posedge clk_i) disable iff (!arst_n_i)
        (ce_i && dctl_mode == BPM_MODE_OFF) |=> (data_bp_event_o == '0);
    endproperty
    a_data_off: assert property (p_data_off) else $error("data event in mode 0");

    property p_count;
        @(posedge clk_i) disable iff (!arst_n_i)
        data_bp_count_o == 2'($countones(data_bp_event_o));
    endproperty
    a_count: assert property (p_count) else $error("count disagrees");

    property p_both_needs_addr;
        @(posedge clk_i) disable iff (!arst_n_i)
        (ce_i && dctl_mode == BPM_MODE_BOTH && !dctl_rinv &&
         (ls_addr_i[0] < dlow_q || ls_addr_i[0] > dhigh_q)) |=> !data_bp_event_o[0];
    endproperty
    a_both_needs_addr: assert property (p_both_needs_addr) else $error("mode 3 no addr");

    property p_value_differ;
        @(posedge clk_i) disable iff (!arst_n_i)
        (ce_i && dctl_mode == BPM_MODE_VALUE && dctl_vinv && dctl_stores &&
         ls_valid_i[1] && ls_store_i[1] &&
         ((ls_data_i[1] & dmask_q) != (dval_q & dmask_q))) |=> data_bp_event_o[1];
    endproperty
    a_value_differ: assert property (p_value_differ) else $error("differ missed");

    property p_port0_load;
        @(posedge clk_i) disable iff (!arst_n_i)
        (ce_i && ls_valid_i[0] && !ls_store_i[0] && !dctl_loads) |=> !data_bp_event_o[0];
    endproperty
    a_port0_load: assert property (p_port0_load) else $error("unselected load hit");

    property p_freeze;
        @(posedge clk_i) disable iff (!arst_n_i)
        !ce_i |=> ($stable(data_bp_event_o) && $stable(instr_bp_event_o));
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with ce low");

    // non-inverted: above the high bound stays quiet
    property p_instr_miss;
        @(posedge clk_i) disable iff (!arst_n_i)
        (ce_i && !ictl_inv && instr_addr_i > ihigh_q) |=> !instr_bp_event_o;
    endproperty
    a_instr_miss: assert property (p_instr_miss) else $error("instr hit above range");

    property p_load_in_range;
        @(posedge clk_i) disable iff (!arst_n_i)
        (ce_i && dctl_mode == BPM_MODE_ADDR && dctl_loads && !dctl_rinv &&
         ls_valid_i[0] && !ls_store_i[0] &&
         ls_addr_i[0] >= dlow_q && ls_addr_i[0] <= dhigh_q) |=> data_bp_event_o[0];
    endproperty
    a_load_in_range: assert property (p_load_in_range) else $error("range hit missed");

    property p_value_equal;
        @(posedge clk_i) disable iff (!arst_n_i)
        (ce_i && dctl_mode == BPM_MODE_VALUE && !dctl_vinv && dctl_loads &&
         ls_valid_i[0] && !ls_store_i[0] &&
         ((ls_data_i[0] & dmask_q) == (dval_q & dmask_q))) |=> data_bp_event_o[0];
    endproperty
    a_value_equal: assert property (p_value_equal) else $error("value hit missed");

    property p_port1_store;
        @(posedge clk_i) disable iff (!arst_n_i)
        (ce_i && ls_valid_i[1] && ls_store_i[1] && !dctl_stores) |=> !data_bp_event_o[1];
    endproperty
    a_port1_store: assert property (p_port1_store) else $error("unselected store hit");

    // controls read zero once reset lifts
    property p_ctl_clear;
        @(posedge clk_i)
        $rose(arst_n_i) |-> (ictl_q == BPM_ICTL_RESET && dctl_q == BPM_DCTL_RESET);
    endproperty
    a_ctl_clear: assert property (p_ctl_clear) else $error("controls not cleared");

    c_instr: cover property (@(posedge clk_i) disable iff (!arst_n_i) instr_bp_event_o);
    c_two:   cover property (@(posedge clk_i) disable iff (!arst_n_i) data_bp_count_o == 2'h2);
    c_both:  cover property (@(posedge clk_i) disable iff (!arst_n_i)
                             dctl_mode == BPM_MODE_BOTH ##1 data_bp_event_o[0]);

endmodule

// file: verif/bpm_core_model.sv
/*
 * core-side model for the breakpoint match unit: one instruction fetch
 * port and two load/store ports, driven through the issue task.
 * assumes the caller runs on the same clock; outputs change only by
 * non-blocking assignment at a rising edge and are released one edge later.
 */
`timescale 1ns/1ps
module bpm_core_model (
    input  wire logic        clk_i,         // cpu clock
    output logic             instr_valid_o, // fetch issued
    output logic [31:0]      instr_addr_o,  // fetch address
    output logic [1:0]       ls_valid_o,    // access issued per port
    output logic [1:0]       ls_store_o,    // 1 store, 0 load
    output logic [1:0][31:0] ls_addr_o,     // access address per port
    output logic [1:0][31:0] ls_data_o      // access data per port
);
    // ************************************************************
    // idle state at time zero
    // ************************************************************
    initial begin
        {instr_valid_o, ls_valid_o, ls_store_o} = '0;
        instr_addr_o = '0;
        ls_addr_o = '0;
        ls_data_o = '0;
    end

    // ************************************************************
    // one cycle of fetch and load/store traffic
    // ************************************************************
    // released address and data lines show the inverse of their last value; valids drop to zero, store flags hold
    task automatic issue(input logic iv, input logic [31:0] ia, input logic [1:0] lv, st,
                         input logic [31:0] a0, a1, d0, d1);
        @(posedge clk_i);
        instr_valid_o <= iv;
        instr_addr_o  <= ia;
        ls_valid_o    <= lv;
        ls_store_o    <= st;
        ls_addr_o     <= {a1, a0};
        ls_data_o     <= {d1, d0};
        @(posedge clk_i);
        instr_valid_o <= 1'b0;
        ls_valid_o    <= 2'b00;
        instr_addr_o  <= ~ia;
        ls_addr_o     <= ~{a1, a0};
        ls_data_o     <= ~{d1, d0};
    endtask
endmodule

// file: verif/tb_top.sv
/*
 * self-checking bench for the breakpoint match unit: register tasks,
 * instruction range scenarios and a table of data match cases.
 * assumes bpm_pkg and bpm_unit compiled first, and the core model beside.
 */
`timescale 1ns/1ps
module tb_top;
    import bpm_pkg::*;

    // ************************************************************
    // clock, reset and register port signals
    // ************************************************************
    logic             clk_i;      // 125 MHz cpu clock
    logic             arst_n;     // async reset, low
    logic             ce;         // clock enable
    logic [31:0]      reg_addr;   // register offset
    logic             reg_wr;     // write strobe
    logic             reg_rd;     // read strobe
    logic [31:0]      reg_wdata;  // write data
    logic [31:0]      rdata;      // read data
    logic             iv;         // fetch valid from core
    logic [31:0]      ia;         // fetch address from core
    logic [1:0]       lv;         // access valid from core
    logic [1:0]       ls;         // store flags from core
    logic [1:0][31:0] la;         // access addresses from core
    logic [1:0][31:0] ld;         // access data from core
    logic             iev;        // instruction event
    logic [1:0]       dev;        // data events per port
    logic [1:0]       dcnt;       // data events this cycle
    int               fail_count; // mismatches seen
    int               num_checks; // comparisons made

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    bpm_core_model core (.clk_i(clk_i), .instr_valid_o(iv), .instr_addr_o(ia),
        .ls_valid_o(lv), .ls_store_o(ls), .ls_addr_o(la), .ls_data_o(ld));

    bpm_unit dut (.clk_i(clk_i), .arst_n_i(arst_n), .ce_i(ce), .reg_addr_i(reg_addr),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata), .reg_rdata_o(rdata),
        .instr_valid_i(iv), .instr_addr_i(ia), .ls_valid_i(lv), .ls_store_i(ls),
        .ls_addr_i(la), .ls_data_i(ld), .instr_bp_event_o(iev), .data_bp_event_o(dev),
        .data_bp_count_o(dcnt));

    // ************************************************************
    // compare, register access and closing tasks
    // ************************************************************
    task automatic check(input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, d);
        @(posedge clk_i);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_i);
        reg_wr <= 1'b0;
    endtask

    // read data lands one cycle after the taken strobe
    task automatic rdchk(input logic [31:0] a, exp);
        @(posedge clk_i);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_i);
        reg_rd <= 1'b0;
        #1 check(rdata, exp);
    endtask

    // one fetch, event the cycle after, gone the cycle after that
    task automatic ichk(input logic [31:0] a, input logic exp);
        core.issue(1'b1, a, 2'b00, 2'b00, '0, '0, '0, '0);
        #1 check({31'h0000_0000, iev}, {31'h0000_0000, exp});
        @(posedge clk_i);
        #1 check({31'h0000_0000, iev}, 32'h0000_0000);
    endtask

    // both ports issue together: port 0 loads, port 1 stores
    task automatic dcase(input logic [31:0] ctl, a0, a1, d0, d1, input logic [1:0] exp);
        wr(BPM_OFF_DATA_CTL, ctl);
        core.issue(1'b0, '0, 2'b11, 2'b10, a0, a1, d0, d1);
        #1 check({30'h0000_0000, dev}, {30'h0000_0000, exp});
        check({30'h0000_0000, dcnt}, 32'(exp[0]) + 32'(exp[1]));
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ************************************************************
    // watchdog, far beyond the hundred-odd cycles the tests need
    // ************************************************************
    initial begin
        #(8 * 20000);
        fail_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        end_sim();
    end

    // ************************************************************
    // test sequence
    // ************************************************************
    initial begin
        logic [31:0] pts [4];
        pts = '{32'h0000_00FF, 32'h0000_0100, 32'h0000_01FF, 32'h0000_0200};
        {arst_n, reg_wr, reg_rd} = 3'b000;
        ce = 1'b1;
        reg_addr = '0;
        reg_wdata = '0;
        fail_count = 0;
        num_checks = 0;
        repeat (10) @(posedge clk_i);
        arst_n <= 1'b1;
        rdchk(BPM_OFF_INSTR_CTL, 32'h0000_0000);
        rdchk(BPM_OFF_DATA_CTL, 32'h0000_0000);
        rdchk(32'h0010_1040, 32'h0000_0000);
        wr(BPM_OFF_INSTR_LOW, 32'h0000_0100);
        wr(BPM_OFF_INSTR_HIGH, 32'h0000_01FF);
        ichk(32'h0000_0150, 1'b0);
        // inside then outside, boundaries on both sides
        for (int k = 0; k < 2; k++) begin
            wr(BPM_OFF_INSTR_CTL, k == 0 ? 32'h0000_0001 : 32'h0000_0003);
            for (int j = 0; j < 4; j++)
                ichk(pts[j], (j == 1 || j == 2) ^ k[0]);
        end
        $display("test instruction match done");
        wr(BPM_OFF_DATA_LOW, 32'h0000_2000);
        wr(BPM_OFF_DATA_HIGH, 32'h0000_2FFF);
        wr(BPM_OFF_DATA_VALUE, 32'h0000_00A5);
        wr(BPM_OFF_DATA_MASK, 32'h0000_00FF);
        rdchk(BPM_OFF_DATA_LOW, 32'h0000_2000);
        rdchk(BPM_OFF_DATA_MASK, 32'h0000_00FF);
        // a write with the clock enable low is ignored
        @(posedge clk_i) ce <= 1'b0;
        wr(BPM_OFF_DATA_HIGH, 32'h0000_0000);
        ce <= 1'b1;
        rdchk(BPM_OFF_DATA_HIGH, 32'h0000_2FFF);
        $display("test registers done");
        dcase(32'h0000_000C, 32'h0000_2000, 32'h0000_2000, 32'h0000_00A5, 32'h0000_00A5,
              2'b00);
        dcase(32'h0000_0005, 32'h0000_2000, 32'h0000_2000, 32'h0, 32'h0, 2'b01);
        dcase(32'h0000_0009, 32'h0000_2000, 32'h0000_2000, 32'h0, 32'h0, 2'b10);
        dcase(32'h0000_000D, 32'h0000_1FFF, 32'h0000_2FFF, 32'h0, 32'h0, 2'b10);
        dcase(32'h0000_000D, 32'h0000_2000, 32'h0000_3000, 32'h0, 32'h0, 2'b01);
        dcase(32'h0000_001D, 32'h0000_1FFF, 32'hE000_0000, 32'h0, 32'h0,
              2'b11);
        dcase(32'h0000_000E, 32'h0000_1FFF, 32'h0000_3000, 32'h1234_56A5, 32'h0000_00A4,
              2'b01);
        dcase(32'h0000_002E, 32'h0000_1FFF, 32'h0000_3000, 32'h1234_56A5, 32'h0000_00A4,
              2'b10);
        dcase(32'h0000_000F, 32'h0000_2000, 32'h0000_3000, 32'h0000_00A5, 32'h0000_00A5,
              2'b01);
        dcase(32'h0000_000F, 32'h0000_2800, 32'h0000_2800, 32'h0000_00A4, 32'hFFFF_FFA5,
              2'b10);
        $display("test data match done");
        // a second reset in mid-run clears both programmed controls
        @(posedge clk_i) arst_n <= 1'b0;
        repeat (2) @(posedge clk_i);
        arst_n <= 1'b1;
        rdchk(BPM_OFF_INSTR_CTL, 32'h0000_0000);
        rdchk(BPM_OFF_DATA_CTL, 32'h0000_0000);
        ichk(32'h0000_0150, 1'b0);
        $display("test reset done");
        end_sim();
    end
endmodule
